// [rtl/cfsb_regs.vh]
// command codes, bit positions and reset values of the converter
// status bank; included by every design file of the bank
`ifndef CFSB_REGS_VH
`define CFSB_REGS_VH

`define CFSB_CMD_SUMMARY 8'h79
`define CFSB_CMD_VOUT_STAT 8'h7a
`define CFSB_CMD_IOUT_STAT 8'h7b
`define CFSB_CMD_INPUT_STAT 8'h7c
`define CFSB_CMD_TEMP_STAT 8'h7d
`define CFSB_CMD_COMM_STAT 8'h7e
`define CFSB_CMD_RD_VIN 8'h88
`define CFSB_CMD_READ_VOUT 8'h8b
`define CFSB_CMD_RD_IOUT 8'h8c
`define CFSB_CMD_READ_TEMP 8'h8d
`define CFSB_CMD_DEV_TYPE 8'hd0
`define CFSB_CMD_VOUT_CAL_GAIN 8'hd1
`define CFSB_CMD_VOUT_CAL_OFS 8'hd2
`define CFSB_CMD_VIN_CAL_GAIN 8'hd3
`define CFSB_CMD_VIN_CAL_OFS 8'hd4
`define CFSB_CMD_IOUT_CAL_GAIN 8'hd6
`define CFSB_CMD_IOUT_CAL_OFS 8'hd7

// summary word bit positions
`define CFSB_SW_VOUT 15
`define CFSB_SW_CURRENT_POWER 14
`define CFSB_SW_INPUT 13
`define CFSB_SW_MFR 12
`define CFSB_SW_POWER_GOOD_NEG 11
`define CFSB_SW_FANS 10
`define CFSB_SW_OTHER 9
`define CFSB_SW_UNKNOWN 8
`define CFSB_SW_BUSY 7
`define CFSB_SW_OUTPUT_OFF 6
`define CFSB_SW_VOUT_OV 5
`define CFSB_SW_IOUT_OC 4
`define CFSB_SW_VIN_UV 3
`define CFSB_SW_TEMP 2
`define CFSB_SW_COMM 1
`define CFSB_SW_NONE 0

// status byte bit positions
`define CFSB_VSTAT_OV 7
`define CFSB_ISTAT_OC 7
`define CFSB_ISTAT_OCW 5
`define CFSB_INSTAT_OV 7
`define CFSB_INSTAT_UV 4
`define CFSB_INSTAT_OFF 3
`define CFSB_TSTAT_OT 7
`define CFSB_TSTAT_OTW 6
`define CFSB_COMM_INVALID_CMD 7
`define CFSB_COMM_INVALID_DATA 6
`define CFSB_COMM_PEC_FAIL 5

// implemented bits of each status byte
`define CFSB_VOUT_MASK 8'h80
`define CFSB_IOUT_MASK 8'ha0
`define CFSB_INPUT_MASK 8'h98
`define CFSB_TEMP_MASK 8'hc0
`define CFSB_COMM_MASK 8'he0

// device type word layout and reset values
`define CFSB_DT_NAME_HI 7
`define CFSB_DT_NAME_LO 2
`define CFSB_DT_PROT 1
`define CFSB_DT_PROT_RESET 1'h1
`define CFSB_CAL_GAIN_RESET 16'h2000
`define CFSB_CAL_OFS_RESET 16'h0000

`endif

// [rtl/cfsb_sticky.v]
// one latched status byte: fault events set bits, a write of ones
// resets them; bits outside the implemented mask never leave zero
`include "cfsb_regs.vh"

module cfsb_sticky #(
  parameter [7:0] IMPL_MASK = 8'hff
) (
  input wire clk,
  input wire rst,
  input wire [7:0] set_bits,
  input wire [7:0] clr_bits,
  output reg [7:0] flags_reg
);

  wire [7:0] flags_next;

  // a set in the clearing cycle survives the clear
  assign flags_next = ((flags_reg & ~clr_bits) | set_bits) & IMPL_MASK;

  always @(posedge clk) begin
    if (rst) begin
      flags_reg <= 8'h00;
    end else begin
      flags_reg <= flags_next;
    end
  end

endmodule // cfsb_sticky

// [rtl/cfsb_bank.v]
// status and telemetry command bank of a converter management port
// assumes a bus engine on clk that hands over one decoded command per
// cycle with its data, and fault events from the converter controller
// Overview of operation
// - read-only 16-bit summary status word with class and fault flags
// - busy, fan, maker, unknown and none-of-above flags always read zero
// - output-voltage byte latches overvoltage fault at bit 7, resettable
// - output-current byte latches fault bit 7 and warning bit 5
// - input byte latches overvoltage 7, undervoltage 4, unit-off 3
// - temperature byte latches fault bit 7 and warning bit 6
// - comm byte flags invalid command 7, invalid data 6, check fail 5
// - telemetry reads return input voltage, output voltage, current, temp
// - device type word: high byte reserved, name bits 7:2, bit 0 reserved
// - device type bit 1 is write protect enable, 0 means inactive
// - write protect enable at 1 protects; it powers up as 1
// - while protected, writes to calibration commands are locked out
`include "cfsb_regs.vh"

module cfsb_bank #(
  // module name code; value arbitrary
  parameter [5:0] MODULE_NAME = 6'h21,
  parameter CAL_COUNT = 6
) (
  input wire clk,
  input wire rst,
  input wire cmd_valid,
  input wire cmd_write,
  input wire [7:0] cmd_code,
  input wire [15:0] cmd_wdata,
  input wire pec_fail,
  input wire evt_output_overvoltage_fault,
  input wire evt_output_overcurrent_fault,
  input wire evt_output_overcurrent_warning,
  input wire evt_input_overvoltage_fault,
  input wire evt_input_undervoltage_fault,
  input wire evt_unit_off_low_vin,
  input wire evt_overtemperature_fault,
  input wire evt_overtemperature_warning,
  input wire power_good_negated,
  input wire output_off,
  input wire [15:0] input_voltage_reading,
  input wire [15:0] output_voltage_reading,
  input wire [15:0] output_current_reading,
  input wire [15:0] temperature_reading,
  output reg rsp_valid_reg,
  output reg rsp_error_reg,
  output reg [15:0] rsp_data_reg,
  output reg [15:0] summary_word_reg,
  output reg write_protect_enable_reg,
  output reg [16*CAL_COUNT-1:0] cal_values_reg
);

  wire [7:0] vout_stat;
  wire [7:0] iout_stat;
  wire [7:0] input_stat;
  wire [7:0] temp_stat;
  wire [7:0] comm_stat;
  reg [15:0] summary_next;
  reg [15:0] rdata_next;
  reg known_cmd;
  reg writable_cmd;
  reg is_cal;
  reg [2:0] cal_idx;
  reg [5:0] module_name_reg;
  reg [7:0] comm_set;
  wire wr;
  wire rd;
  wire cal_write_ok;
  wire [7:0] wbyte;

  assign wr = cmd_valid & cmd_write;
  assign rd = cmd_valid & ~cmd_write;
  assign wbyte = cmd_wdata[7:0];

  // command decode and calibration slot index
  always @* begin
    known_cmd = 1'b1;
    writable_cmd = 1'b0;
    is_cal = 1'b0;
    cal_idx = 3'h0;
    case (cmd_code)
      `CFSB_CMD_SUMMARY,
      `CFSB_CMD_RD_VIN,
      `CFSB_CMD_READ_VOUT,
      `CFSB_CMD_RD_IOUT,
      `CFSB_CMD_READ_TEMP: begin
        writable_cmd = 1'b0;
      end
      `CFSB_CMD_VOUT_STAT,
      `CFSB_CMD_IOUT_STAT,
      `CFSB_CMD_INPUT_STAT,
      `CFSB_CMD_TEMP_STAT,
      `CFSB_CMD_COMM_STAT,
      `CFSB_CMD_DEV_TYPE: begin
        writable_cmd = 1'b1;
      end
      `CFSB_CMD_VOUT_CAL_GAIN: begin
        writable_cmd = 1'b1;
        is_cal = 1'b1;
        cal_idx = 3'h0;
      end
      `CFSB_CMD_VOUT_CAL_OFS: begin
        writable_cmd = 1'b1;
        is_cal = 1'b1;
        cal_idx = 3'h1;
      end
      `CFSB_CMD_VIN_CAL_GAIN: begin
        writable_cmd = 1'b1;
        is_cal = 1'b1;
        cal_idx = 3'h2;
      end
      `CFSB_CMD_VIN_CAL_OFS: begin
        writable_cmd = 1'b1;
        is_cal = 1'b1;
        cal_idx = 3'h3;
      end
      `CFSB_CMD_IOUT_CAL_GAIN: begin
        writable_cmd = 1'b1;
        is_cal = 1'b1;
        cal_idx = 3'h4;
      end
      `CFSB_CMD_IOUT_CAL_OFS: begin
        writable_cmd = 1'b1;
        is_cal = 1'b1;
        cal_idx = 3'h5;
      end
      default: begin
        known_cmd = 1'b0;
      end
    endcase
  end

  assign cal_write_ok = wr & is_cal & ~write_protect_enable_reg;

  always @* begin
    comm_set = 8'h00;
    comm_set[`CFSB_COMM_INVALID_CMD] = cmd_valid & ~known_cmd;
    comm_set[`CFSB_COMM_INVALID_DATA] = wr & known_cmd &
      (~writable_cmd | (is_cal & write_protect_enable_reg));
    comm_set[`CFSB_COMM_PEC_FAIL] = pec_fail;
  end

  cfsb_sticky #(.IMPL_MASK(`CFSB_VOUT_MASK)) u_vout (
    .clk(clk),
    .rst(rst),
    .set_bits({evt_output_overvoltage_fault, 7'h00}),
    .clr_bits((wr && cmd_code == `CFSB_CMD_VOUT_STAT) ? wbyte : 8'h00),
    .flags_reg(vout_stat)
  );

  cfsb_sticky #(.IMPL_MASK(`CFSB_IOUT_MASK)) u_iout (
    .clk(clk),
    .rst(rst),
    .set_bits({evt_output_overcurrent_fault, 1'b0,
      evt_output_overcurrent_warning, 5'h00}),
    .clr_bits((wr && cmd_code == `CFSB_CMD_IOUT_STAT) ? wbyte : 8'h00),
    .flags_reg(iout_stat)
  );

  cfsb_sticky #(.IMPL_MASK(`CFSB_INPUT_MASK)) u_input (
    .clk(clk),
    .rst(rst),
    .set_bits({evt_input_overvoltage_fault, 2'h0,
      evt_input_undervoltage_fault,
      evt_unit_off_low_vin, 3'h0}),
    .clr_bits((wr && cmd_code == `CFSB_CMD_INPUT_STAT) ? wbyte : 8'h00),
    .flags_reg(input_stat)
  );

  cfsb_sticky #(.IMPL_MASK(`CFSB_TEMP_MASK)) u_temp (
    .clk(clk),
    .rst(rst),
    .set_bits({evt_overtemperature_fault, evt_overtemperature_warning,
      6'h00}),
    .clr_bits((wr && cmd_code == `CFSB_CMD_TEMP_STAT) ? wbyte : 8'h00),
    .flags_reg(temp_stat)
  );

  // communication byte; masks keep unused bits at zero
  cfsb_sticky #(.IMPL_MASK(`CFSB_COMM_MASK)) u_comm (
    .clk(clk),
    .rst(rst),
    .set_bits(comm_set),
    .clr_bits((wr && cmd_code == `CFSB_CMD_COMM_STAT) ? wbyte : 8'h00),
    .flags_reg(comm_stat)
  );

  always @* begin
    summary_next = 16'h0000;
    summary_next[`CFSB_SW_VOUT] = |vout_stat;
    summary_next[`CFSB_SW_CURRENT_POWER] = |iout_stat;
    summary_next[`CFSB_SW_INPUT] = |input_stat;
    summary_next[`CFSB_SW_POWER_GOOD_NEG] = power_good_negated;
    summary_next[`CFSB_SW_OUTPUT_OFF] = output_off;
    summary_next[`CFSB_SW_VOUT_OV] = vout_stat[`CFSB_VSTAT_OV];
    summary_next[`CFSB_SW_IOUT_OC] = iout_stat[`CFSB_ISTAT_OC];
    summary_next[`CFSB_SW_VIN_UV] = input_stat[`CFSB_INSTAT_UV];
    summary_next[`CFSB_SW_TEMP] = |temp_stat;
    summary_next[`CFSB_SW_COMM] = |comm_stat;
    summary_next[`CFSB_SW_MFR] = 1'b0;
    summary_next[`CFSB_SW_FANS] = 1'b0;
    summary_next[`CFSB_SW_OTHER] = 1'b0;
    summary_next[`CFSB_SW_UNKNOWN] = 1'b0;
    summary_next[`CFSB_SW_BUSY] = 1'b0;
    summary_next[`CFSB_SW_NONE] = 1'b0;
  end

  always @(posedge clk) begin
    if (rst) begin
      summary_word_reg <= 16'h0000;
    end else begin
      summary_word_reg <= summary_next;
    end
  end

  // name field writable, reserved bits not stored
  always @(posedge clk) begin
    if (rst) begin
      module_name_reg <= MODULE_NAME;
      write_protect_enable_reg <= `CFSB_DT_PROT_RESET;
    end else if (wr && cmd_code == `CFSB_CMD_DEV_TYPE) begin
      module_name_reg <= wbyte[`CFSB_DT_NAME_HI:`CFSB_DT_NAME_LO];
      write_protect_enable_reg <= wbyte[`CFSB_DT_PROT];
    end
  end

  // calibration factors; gains reset to unity, offsets to zero
  genvar gi;
  generate
    for (gi = 0; gi < CAL_COUNT; gi = gi + 1) begin : g_cal
      always @(posedge clk) begin
        if (rst) begin
          cal_values_reg[16*gi +: 16] <= (gi % 2 == 0) ?
            `CFSB_CAL_GAIN_RESET : `CFSB_CAL_OFS_RESET;
        end else if (cal_write_ok && cal_idx == gi) begin
          cal_values_reg[16*gi +: 16] <= cmd_wdata;
        end
      end
    end
  endgenerate

  // read data selection
  always @* begin
    rdata_next = 16'h0000;
    case (cmd_code)
      `CFSB_CMD_SUMMARY: begin
        rdata_next = summary_next;
      end
      `CFSB_CMD_VOUT_STAT: begin
        rdata_next = {8'h00, vout_stat};
      end
      `CFSB_CMD_IOUT_STAT: begin
        rdata_next = {8'h00, iout_stat};
      end
      `CFSB_CMD_INPUT_STAT: begin
        rdata_next = {8'h00, input_stat};
      end
      `CFSB_CMD_TEMP_STAT: begin
        rdata_next = {8'h00, temp_stat};
      end
      `CFSB_CMD_COMM_STAT: begin
        rdata_next = {8'h00, comm_stat};
      end
      `CFSB_CMD_RD_VIN: begin
        rdata_next = input_voltage_reading;
      end
      `CFSB_CMD_READ_VOUT: begin
        rdata_next = output_voltage_reading;
      end
      `CFSB_CMD_RD_IOUT: begin
        rdata_next = output_current_reading;
      end
      `CFSB_CMD_READ_TEMP: begin
        rdata_next = temperature_reading;
      end
      // high byte and bit 0 reserved zero
      `CFSB_CMD_DEV_TYPE: begin
        rdata_next = {8'h00, module_name_reg, write_protect_enable_reg,
          1'b0};
      end
      default: begin
        if (is_cal) begin
          rdata_next = cal_values_reg[16*cal_idx +: 16];
        end
      end
    endcase
  end

  // one answer per command, one cycle later
  always @(posedge clk) begin
    if (rst) begin
      rsp_valid_reg <= 1'b0;
      rsp_error_reg <= 1'b0;
      rsp_data_reg <= 16'h0000;
    end else begin
      rsp_valid_reg <= cmd_valid;
      rsp_error_reg <= cmd_valid &
        (comm_set[`CFSB_COMM_INVALID_CMD] |
         comm_set[`CFSB_COMM_INVALID_DATA]);
      rsp_data_reg <= (rd && known_cmd) ? rdata_next : 16'h0000;
    end
  end

endmodule // cfsb_bank

// [test/cfsb_bank_asserts.sv]
// assertions on the status bank ports
// assumes one clock and a synchronous active high reset
module cfsb_bank_asserts #(
  parameter CAL_COUNT = 6
) (
  input logic clk,
  input logic rst,
  input logic cmd_valid,
  input logic cmd_write,
  input logic [7:0] cmd_code,
  input logic [15:0] cmd_wdata,
  input logic pec_fail,
  input logic evt_output_overvoltage_fault,
  input logic evt_output_overcurrent_warning,
  input logic evt_input_undervoltage_fault,
  input logic evt_overtemperature_warning,
  input logic power_good_negated,
  input logic rsp_valid_reg,
  input logic rsp_error_reg,
  input logic [15:0] summary_word_reg,
  input logic write_protect_enable_reg,
  input logic [16*CAL_COUNT-1:0] cal_values_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [15:0] sw = summary_word_reg;
  wire wr = cmd_valid && cmd_write;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_rsp_next: assert property (cmd_valid |=> rsp_valid_reg)
    else $error("no answer after command");
  chk_sw_unused: assert property ((sw & 16'h1781) == 16'h0000)
    else $error("unused summary flag set");
  chk_vout_class: assert property
    (evt_output_overvoltage_fault |-> ##2 sw[15] && sw[5])
    else $error("vout fault not in summary");
  chk_iout_warn: assert property
    (evt_output_overcurrent_warning |-> ##2 sw[14])
    else $error("current warning not in summary");
  chk_input_uv: assert property
    (evt_input_undervoltage_fault |-> ##2 sw[13] && sw[3])
    else $error("input fault not in summary");
  chk_temp_warn: assert property
    (evt_overtemperature_warning |-> ##2 sw[2])
    else $error("temperature not in summary");
  chk_pec_comm: assert property (pec_fail |-> ##2 sw[1])
    else $error("check failure not in summary");
  chk_pgood_lag: assert property
    (!$past(rst) |-> sw[11] == $past(power_good_negated))
    else $error("power good flag wrong");
  chk_wpe_reset: assert property ($past(rst) |-> write_protect_enable_reg)
    else $error("protect not on after reset");
  chk_cal_locked: assert property
    (wr && cmd_code == 8'hd1 && write_protect_enable_reg
      |=> rsp_error_reg && $stable(cal_values_reg))
    else $error("locked write accepted");
  chk_class_clear: assert property
    (wr && cmd_code == 8'h7a && cmd_wdata[7] &&
      !evt_output_overvoltage_fault
      |-> ##2 !sw[15])
    else $error("vout class flag stuck");
  cover property (wr && cmd_code == 8'hd0);
  cover property (rsp_error_reg);
  cover property (sw[15] && sw[1]);
endmodule // cfsb_bank_asserts

// [test/cfsb_host.sv]
// host side of the command port, one command at a time
// assumes the bank answers on the edge after it takes a command
module cfsb_host (
  input logic clk,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input logic rsp_valid_reg,
  input logic rsp_error_reg,
  input logic [15:0] rsp_data_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  task automatic xfer(input logic w, input logic [7:0] c,
      input logic [15:0] d, output logic [16:0] r, output logic to);
    int n;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = c;
    cmd_wdata = d;
    @(negedge clk);
    cmd_valid = 1'b0;
    // released lines flip so a stale command is never seen
    cmd_write = ~w;
    cmd_code = ~c;
    cmd_wdata = ~d;
    n = 0;
    while (rsp_valid_reg !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    to = (n == 4);
    r = {rsp_error_reg, rsp_data_reg};
  endtask
endmodule // cfsb_host

// [test/test_cfsb_bank.sv]
// self-checking bench for the status bank
// events and power flags change at the falling edge, telemetry held constant, commands via host
module test_cfsb_bank;
  timeunit 1ns;
  timeprecision 1ps;
  // module name code; value arbitrary
  localparam [5:0] MN = 6'h2a;
  localparam logic [7:0] TC [4] = '{8'h88, 8'h8b, 8'h8c, 8'h8d};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pgn = 1'b0;
  logic off = 1'b0;
  logic [8:0] ev = 9'h000;
  logic [15:0] tel [4] = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0};
  logic [16:0] r;
  logic to;
  wire cv, cw, rv, re;
  wire [7:0] cc;
  wire [15:0] cd, rdat;
  int mismatches = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  cfsb_host i_cfsb_host (.clk(clk), .cmd_valid(cv), .cmd_write(cw),
    .cmd_code(cc), .cmd_wdata(cd), .rsp_valid_reg(rv),
    .rsp_error_reg(re), .rsp_data_reg(rdat));
  cfsb_bank #(.MODULE_NAME(MN)) i_cfsb_bank (.clk(clk), .rst(rst),
    .cmd_valid(cv), .cmd_write(cw), .cmd_code(cc), .cmd_wdata(cd),
    .pec_fail(ev[8]), .evt_output_overvoltage_fault(ev[0]),
    .evt_output_overcurrent_fault(ev[1]),
    .evt_output_overcurrent_warning(ev[2]),
    .evt_input_overvoltage_fault(ev[3]),
    .evt_input_undervoltage_fault(ev[4]),
    .evt_unit_off_low_vin(ev[5]), .evt_overtemperature_fault(ev[6]),
    .evt_overtemperature_warning(ev[7]), .power_good_negated(pgn),
    .output_off(off),
    .input_voltage_reading(tel[0]), .output_voltage_reading(tel[1]),
    .output_current_reading(tel[2]), .temperature_reading(tel[3]),
    .rsp_valid_reg(rv), .rsp_error_reg(re), .rsp_data_reg(rdat),
    .summary_word_reg(), .write_protect_enable_reg(),
    .cal_values_reg());
  task automatic summarize();
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [16:0] e, input logic [16:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d,
      input logic [16:0] e);
    i_cfsb_host.xfer(1'b1, c, d, r, to);
    if (to) begin
      mismatches++;
      summarize();
    end
    cmp(e, r);
  endtask
  task automatic rd(input logic [7:0] c, input logic [16:0] e);
    i_cfsb_host.xfer(1'b0, c, 16'h0000, r, to);
    if (to) begin
      mismatches++;
      summarize();
    end
    cmp(e, r);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    rd(8'hd0, {9'h000, MN, 2'b10});
    rd(8'h79, 17'h00000);
    pgn = 1'b1;
    off = 1'b1;
    ev = 9'h1ff;
    @(negedge clk);
    ev = 9'h000;
    rd(8'h7a, 17'h00080);
    rd(8'h7b, 17'h000a0);
    rd(8'h7c, 17'h00098);
    rd(8'h7d, 17'h000c0);
    rd(8'h7e, 17'h00020);
    rd(8'h79, 17'h0e87e);
    pgn = 1'b0;
    off = 1'b0;
    wr(8'h7a, 16'h00ff, 17'h00000);
    wr(8'h7b, 16'h0020, 17'h00000);
    wr(8'h7c, 16'h0010, 17'h00000);
    wr(8'h7d, 16'h00ff, 17'h00000);
    wr(8'h7e, 16'h00ff, 17'h00000);
    rd(8'h7a, 17'h00000);
    rd(8'h7b, 17'h00080);
    rd(8'h7c, 17'h00088);
    rd(8'h7d, 17'h00000);
    rd(8'h79, 17'h06010);
    foreach (TC[i]) rd(TC[i], {1'b0, tel[i]});
    wr(8'hd1, 16'h1111, 17'h10000);
    rd(8'hd1, 17'h02000);
    rd(8'h7e, 17'h00040);
    wr(8'hd0, {8'h00, MN, 2'b00}, 17'h00000);
    wr(8'hd1, 16'h1111, 17'h00000);
    rd(8'hd1, 17'h01111);
    wr(8'hd0, {8'h00, MN, 2'b10}, 17'h00000);
    wr(8'hd2, 16'h1111, 17'h10000);
    wr(8'h7e, 16'h00ff, 17'h00000);
    rd(8'h55, 17'h10000);
    wr(8'h88, 16'h0001, 17'h10000);
    rd(8'h7e, 17'h000c0);
    rd(8'hd0, {9'h000, MN, 2'b10});
    summarize();
  end
endmodule // test_cfsb_bank
bind cfsb_bank cfsb_bank_asserts #(.CAL_COUNT(CAL_COUNT)) i_asserts (
  .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
  .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .pec_fail(pec_fail),
  .evt_output_overvoltage_fault(evt_output_overvoltage_fault),
  .evt_output_overcurrent_warning(evt_output_overcurrent_warning),
  .evt_input_undervoltage_fault(evt_input_undervoltage_fault),
  .evt_overtemperature_warning(evt_overtemperature_warning),
  .power_good_negated(power_good_negated),
  .rsp_valid_reg(rsp_valid_reg), .rsp_error_reg(rsp_error_reg),
  .summary_word_reg(summary_word_reg),
  .write_protect_enable_reg(write_protect_enable_reg),
  .cal_values_reg(cal_values_reg));
